// ### ldev_cfg_pkg.sv
// constants, field layouts and carriers for the logical device config bank
// assumes an 8-bit indexed register port and a host-written device number
// Behaviour
// [R1] override register readable always, writable only device 04h
// [R2] bits 7,6,3 force fan drive outputs on pins
// [R3] bits 2,1,0 force fan speed inputs on pins
// [R4] bits 5-4 reserved; override resets to zero
// [R5] software leaves vendor test registers at zero
// [R6] floppy activate bit 0 enables controller
// [R7] floppy base high holds address bits 11:8
// [R8] floppy base low holds bits 7:3, resets F0h
// [R9] floppy interrupt level four bits, resets 06h
// [R10] floppy dma channel three bits, resets 02h
// [R11] floppy special one: share, swap, mode, protect
// [R12] floppy special two: data rate selects per drive
// [R13] uart one activate bit 0 enables port
// [R14] uart one base address from high and low
// [R15] uart one interrupt level four bits, resets 04h
// [R16] uart one special: edge suppress and sharing
// [R17] uart one clock source 00 is standard
// [R18] uart two activate bit 0 enables port
// [R19] uart two base address high and low
// [R20] group four selection register resets FFh, per-pin
// [R21] reserved and read-only bits ignore writes, read zero
package ldev_cfg_pkg;
  localparam logic [7:0] DEV_FLOPPY = 8'h00;
  localparam logic [7:0] DEV_UART_ONE = 8'h01;
  localparam logic [7:0] DEV_UART_TWO = 8'h02;
  localparam logic [7:0] DEV_GPIO = 8'h04;

  localparam logic [7:0] IDX_DEVICE_NUMBER = 8'h07;
  localparam logic [7:0] IDX_GROUP4_SELECT = 8'h28;
  localparam logic [7:0] IDX_ALT_OVERRIDE = 8'h2B;
  localparam logic [7:0] IDX_TEST_ONE = 8'h2E;
  localparam logic [7:0] IDX_TEST_TWO = 8'h2F;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_LEVEL = 8'h70;
  localparam logic [7:0] IDX_DMA_CHANNEL = 8'h74;
  localparam logic [7:0] IDX_SPECIAL_ONE = 8'hF0;
  localparam logic [7:0] IDX_SPECIAL_TWO = 8'hF1;

  localparam logic [7:0] RST_GROUP4_SELECT = 8'hFF;
  localparam logic [7:0] RST_ALT_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_ACTIVATE = 8'h00;
  localparam logic [7:0] RST_FLOPPY_BASE_HIGH = 8'h03;
  localparam logic [7:0] RST_FLOPPY_BASE_LOW = 8'hF0;
  localparam logic [7:0] RST_UART_ONE_BASE_HIGH = 8'h03;
  localparam logic [7:0] RST_UART_TWO_BASE_HIGH = 8'h02;
  localparam logic [7:0] RST_UART_BASE_LOW = 8'hF8;
  localparam logic [7:0] RST_FLOPPY_IRQ = 8'h06;
  localparam logic [7:0] RST_UART_ONE_IRQ = 8'h04;
  localparam logic [7:0] RST_FLOPPY_DMA = 8'h02;
  localparam logic [7:0] RST_SPECIAL = 8'h00;

  // writable-bit masks; every other bit reads zero
  localparam logic [7:0] MASK_ALT_OVERRIDE = 8'hCF;
  localparam logic [7:0] MASK_ENABLE = 8'h01;
  localparam logic [7:0] MASK_BASE_HIGH = 8'h0F;
  localparam logic [7:0] MASK_BASE_LOW = 8'hF8;
  localparam logic [7:0] MASK_IRQ = 8'h0F;
  localparam logic [7:0] MASK_DMA = 8'h07;
  localparam logic [7:0] MASK_FLOPPY_SPECIAL = 8'h0F;
  localparam logic [7:0] MASK_UART_SPECIAL = 8'h0F;

  localparam int BIT_PIN56 = 7;
  localparam int BIT_PIN55 = 6;
  localparam int BIT_PIN52 = 3;
  localparam int BIT_PIN51 = 2;
  localparam int BIT_PIN50 = 1;
  localparam int BIT_PIN49 = 0;
  localparam logic [1:0] CLK_SRC_STANDARD = 2'h0;

  typedef struct packed {
    logic enable;
    logic [15:0] base;
    logic [3:0] irq_level;
    logic [2:0] dma_channel;
    logic irq_share;
    logic drive_swap;
    logic three_mode;
    logic write_protect;
    logic [1:0] rate_b;
    logic [1:0] rate_a;
  } floppy_cfg_t;

  typedef struct packed {
    logic enable;
    logic [15:0] base;
    logic [3:0] irq_level;
    logic suppress_mcr_fall;
    logic clk_standard;
    logic irq_share;
  } uart_cfg_t;

  typedef struct packed {
    logic enable;
    logic [15:0] base;
  } uart_base_t;

  // per pin 49..56: 1 joystick, 2 gpio, 3 fan alternate (one-hot after reset; reset clears all three)
  typedef struct packed {
    logic [7:0] joystick;
    logic [7:0] gpio;
    logic [7:0] fan;
  } pin_func_t;
endpackage

// ### logical_device_config_regs.sv
// configuration register bank behind an indexed port per logical device
// assumes the host writes the device number at its own index first
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module logical_device_config_regs
  import ldev_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // decoded configuration
  output floppy_cfg_t floppy_cfg,
  output uart_cfg_t uart_one_cfg,
  output uart_base_t uart_two_cfg,
  output pin_func_t pin_func
);

////////////////////////////////////////////////////////////////////////////
  logic [7:0] logical_device_number_ff;
  logic [7:0] group4_select_ff, alt_override_ff, test_one_ff, test_two_ff;
  logic [7:0] fl_act_ff, fl_bh_ff, fl_bl_ff, fl_irq_ff, fl_dma_ff;
  logic [7:0] fl_sp1_ff, fl_sp2_ff;
  logic [7:0] u1_act_ff, u1_bh_ff, u1_bl_ff, u1_irq_ff, u1_sp_ff;
  logic [7:0] u2_act_ff, u2_bh_ff, u2_bl_ff;
  logic [7:0] nxt_rdata;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] dev);
    hit = reg_wr && reg_addr == idx && logical_device_number_ff == dev;
  endfunction

  function automatic logic [15:0] base_of(input logic [7:0] hi,
                                         input logic [7:0] lo);
    base_of = {4'h0, hi[3:0], lo[7:3], 3'h0};
  endfunction

////////////////////////////////////////////////////////////////////////////
  // global registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      logical_device_number_ff <= DEV_FLOPPY;
      group4_select_ff <= RST_GROUP4_SELECT; // R20
      alt_override_ff <= RST_ALT_OVERRIDE; // R4
      test_one_ff <= RST_TEST; // R5
      test_two_ff <= RST_TEST; // R5
    end else if (reg_wr) begin
      case (reg_addr)
        IDX_DEVICE_NUMBER: logical_device_number_ff <= reg_wdata;
        IDX_GROUP4_SELECT: group4_select_ff <= reg_wdata;
        IDX_ALT_OVERRIDE: begin
          if (logical_device_number_ff == DEV_GPIO) begin // R1
            alt_override_ff <= reg_wdata & MASK_ALT_OVERRIDE; // R4 R21
          end
        end
        IDX_TEST_ONE: test_one_ff <= reg_wdata;
        IDX_TEST_TWO: test_two_ff <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // floppy controller registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fl_act_ff <= RST_ACTIVATE; // R6
      fl_bh_ff <= RST_FLOPPY_BASE_HIGH; // R7
      fl_bl_ff <= RST_FLOPPY_BASE_LOW; // R8
      fl_irq_ff <= RST_FLOPPY_IRQ; // R9
      fl_dma_ff <= RST_FLOPPY_DMA; // R10
      fl_sp1_ff <= RST_SPECIAL; // R11
      fl_sp2_ff <= RST_SPECIAL; // R12
    end else begin
      if (hit(IDX_ACTIVATE, DEV_FLOPPY)) begin
        fl_act_ff <= reg_wdata & MASK_ENABLE; // R6 R21
      end
      if (hit(IDX_BASE_HIGH, DEV_FLOPPY)) begin
        fl_bh_ff <= reg_wdata & MASK_BASE_HIGH; // R7
      end
      if (hit(IDX_BASE_LOW, DEV_FLOPPY)) begin
        fl_bl_ff <= reg_wdata & MASK_BASE_LOW; // R8
      end
      if (hit(IDX_IRQ_LEVEL, DEV_FLOPPY)) begin
        fl_irq_ff <= reg_wdata & MASK_IRQ; // R9
      end
      if (hit(IDX_DMA_CHANNEL, DEV_FLOPPY)) begin
        fl_dma_ff <= reg_wdata & MASK_DMA; // R10
      end
      if (hit(IDX_SPECIAL_ONE, DEV_FLOPPY)) begin
        fl_sp1_ff <= reg_wdata & MASK_FLOPPY_SPECIAL; // R11
      end
      if (hit(IDX_SPECIAL_TWO, DEV_FLOPPY)) begin
        fl_sp2_ff <= reg_wdata & MASK_FLOPPY_SPECIAL; // R12
      end
    end
  end

  // first serial port registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      u1_act_ff <= RST_ACTIVATE; // R13
      u1_bh_ff <= RST_UART_ONE_BASE_HIGH; // R14
      u1_bl_ff <= RST_UART_BASE_LOW; // R14
      u1_irq_ff <= RST_UART_ONE_IRQ; // R15
      u1_sp_ff <= RST_SPECIAL; // R16
    end else begin
      if (hit(IDX_ACTIVATE, DEV_UART_ONE)) begin
        u1_act_ff <= reg_wdata & MASK_ENABLE; // R13
      end
      if (hit(IDX_BASE_HIGH, DEV_UART_ONE)) begin
        u1_bh_ff <= reg_wdata & MASK_BASE_HIGH; // R14
      end
      if (hit(IDX_BASE_LOW, DEV_UART_ONE)) begin
        u1_bl_ff <= reg_wdata & MASK_BASE_LOW; // R14
      end
      if (hit(IDX_IRQ_LEVEL, DEV_UART_ONE)) begin
        u1_irq_ff <= reg_wdata & MASK_IRQ; // R15
      end
      if (hit(IDX_SPECIAL_ONE, DEV_UART_ONE)) begin
        u1_sp_ff <= reg_wdata & MASK_UART_SPECIAL; // R16 R17
      end
    end
  end

  // second serial port registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      u2_act_ff <= RST_ACTIVATE; // R18
      u2_bh_ff <= RST_UART_TWO_BASE_HIGH; // R19
      u2_bl_ff <= RST_UART_BASE_LOW; // R19
    end else begin
      if (hit(IDX_ACTIVATE, DEV_UART_TWO)) begin
        u2_act_ff <= reg_wdata & MASK_ENABLE; // R18
      end
      if (hit(IDX_BASE_HIGH, DEV_UART_TWO)) begin
        u2_bh_ff <= reg_wdata & MASK_BASE_HIGH; // R19
      end
      if (hit(IDX_BASE_LOW, DEV_UART_TWO)) begin
        u2_bl_ff <= reg_wdata & MASK_BASE_LOW; // R19
      end
    end
  end

////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped index or device reads zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      IDX_DEVICE_NUMBER: nxt_rdata = logical_device_number_ff;
      IDX_GROUP4_SELECT: nxt_rdata = group4_select_ff;
      IDX_ALT_OVERRIDE: nxt_rdata = alt_override_ff; // R1
      IDX_TEST_ONE: nxt_rdata = test_one_ff;
      IDX_TEST_TWO: nxt_rdata = test_two_ff;
      default: begin
        case (logical_device_number_ff)
          DEV_FLOPPY: begin
            case (reg_addr)
              IDX_ACTIVATE: nxt_rdata = fl_act_ff;
              IDX_BASE_HIGH: nxt_rdata = fl_bh_ff;
              IDX_BASE_LOW: nxt_rdata = fl_bl_ff;
              IDX_IRQ_LEVEL: nxt_rdata = fl_irq_ff;
              IDX_DMA_CHANNEL: nxt_rdata = fl_dma_ff;
              IDX_SPECIAL_ONE: nxt_rdata = fl_sp1_ff;
              IDX_SPECIAL_TWO: nxt_rdata = fl_sp2_ff;
              default: nxt_rdata = 8'h00;
            endcase
          end
          DEV_UART_ONE: begin
            case (reg_addr)
              IDX_ACTIVATE: nxt_rdata = u1_act_ff;
              IDX_BASE_HIGH: nxt_rdata = u1_bh_ff;
              IDX_BASE_LOW: nxt_rdata = u1_bl_ff;
              IDX_IRQ_LEVEL: nxt_rdata = u1_irq_ff;
              IDX_SPECIAL_ONE: nxt_rdata = u1_sp_ff;
              default: nxt_rdata = 8'h00;
            endcase
          end
          DEV_UART_TWO: begin
            case (reg_addr)
              IDX_ACTIVATE: nxt_rdata = u2_act_ff;
              IDX_BASE_HIGH: nxt_rdata = u2_bh_ff;
              IDX_BASE_LOW: nxt_rdata = u2_bl_ff;
              default: nxt_rdata = 8'h00;
            endcase
          end
          default: nxt_rdata = 8'h00;
        endcase
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // decoded outputs, registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      floppy_cfg <= '0;
      uart_one_cfg <= '0;
      uart_two_cfg <= '0;
      pin_func <= '0;
    end else begin
      floppy_cfg.enable <= fl_act_ff[0]; // R6
      floppy_cfg.base <= base_of(fl_bh_ff, fl_bl_ff); // R7 R8
      floppy_cfg.irq_level <= fl_irq_ff[3:0]; // R9
      floppy_cfg.dma_channel <= fl_dma_ff[2:0]; // R10
      floppy_cfg.irq_share <= fl_sp1_ff[3]; // R11
      floppy_cfg.drive_swap <= fl_sp1_ff[2];
      floppy_cfg.three_mode <= fl_sp1_ff[1];
      floppy_cfg.write_protect <= fl_sp1_ff[0];
      floppy_cfg.rate_b <= fl_sp2_ff[3:2]; // R12
      floppy_cfg.rate_a <= fl_sp2_ff[1:0];
      uart_one_cfg.enable <= u1_act_ff[0]; // R13
      uart_one_cfg.base <= base_of(u1_bh_ff, u1_bl_ff); // R14
      uart_one_cfg.irq_level <= u1_irq_ff[3:0]; // R15
      uart_one_cfg.suppress_mcr_fall <= u1_sp_ff[3]; // R16
      uart_one_cfg.clk_standard <= u1_sp_ff[2:1] == CLK_SRC_STANDARD; // R17
      uart_one_cfg.irq_share <= u1_sp_ff[0]; // R16
      uart_two_cfg.enable <= u2_act_ff[0]; // R18
      uart_two_cfg.base <= base_of(u2_bh_ff, u2_bl_ff); // R19
      for (int i = 0; i < 8; i++) begin
        // override wins only on pins that own a fan alternate
        if (alt_override_ff[i] && MASK_ALT_OVERRIDE[i]) begin // R2 R3 R4
          pin_func.fan[i] <= 1'b1;
          pin_func.gpio[i] <= 1'b0;
          pin_func.joystick[i] <= 1'b0;
        end else begin
          pin_func.fan[i] <= 1'b0;
          pin_func.gpio[i] <= group4_select_ff[i]; // R20
          pin_func.joystick[i] <= ~group4_select_ff[i]; // R20
        end
      end
    end
  end
endmodule

// ### host_model.sv
// host side model: drives the indexed register port as software does
// assumes strobes launch by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module host_model
  import ldev_cfg_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    // software never sets the vendor test registers
    reg_wdata <= (a == IDX_TEST_ONE || a == IDX_TEST_TWO) ? 8'h00 : d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_wdata <= ~reg_wdata;
  endtask
  task automatic idle();
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    reg_addr <= ~reg_addr;
  endtask
endmodule

// ### ldev_cfg_properties.sv
// concurrent checks on the configuration bank ports
// assumes it is bound to the bank top and sees only its ports
`timescale 1ns/1ps
module ldev_cfg_properties
  import ldev_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // decoded configuration
  input wire floppy_cfg_t floppy_cfg,
  input wire uart_cfg_t uart_one_cfg,
  input wire uart_base_t uart_two_cfg,
  input wire pin_func_t pin_func
);
  logic [7:0] dev_ff;
  logic [7:0] ovr_ff;
  logic [7:0] grp_ff;
  logic live_ff;
  // shadow of device number, override and group-four selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dev_ff <= 8'h00;
      ovr_ff <= 8'h00;
      grp_ff <= 8'hFF;
      live_ff <= 1'b0;
    end else begin
      live_ff <= 1'b1;
      if (reg_wr && reg_addr == IDX_DEVICE_NUMBER) dev_ff <= reg_wdata;
      if (reg_wr && reg_addr == IDX_GROUP4_SELECT) grp_ff <= reg_wdata;
      if (reg_wr && reg_addr == IDX_ALT_OVERRIDE && dev_ff == DEV_GPIO)
        ovr_ff <= reg_wdata & 8'hCF;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_ovr_read: assert property (
    reg_rd && reg_addr == IDX_ALT_OVERRIDE |=> reg_rdata == ovr_ff)
    else $error("override read mismatch");
  chk_fan_force: assert property (
    live_ff |-> pin_func.fan == $past(ovr_ff))
    else $error("fan function mismatch");
  chk_gpio_sel: assert property (
    live_ff |-> pin_func.gpio == ($past(grp_ff) & ~$past(ovr_ff)))
    else $error("gpio function mismatch");
  chk_joy_sel: assert property (
    live_ff |-> pin_func.joystick == (~$past(grp_ff) & ~$past(ovr_ff)))
    else $error("joystick function mismatch");
  chk_base_align: assert property (
    floppy_cfg.base[15:12] == 4'h0 && floppy_cfg.base[2:0] == 3'h0 &&
    uart_one_cfg.base[15:12] == 4'h0 && uart_one_cfg.base[2:0] == 3'h0 &&
    uart_two_cfg.base[15:12] == 4'h0 && uart_two_cfg.base[2:0] == 3'h0)
    else $error("base address alignment");
  chk_high_rsvd: assert property (
    reg_rd && (reg_addr == IDX_BASE_HIGH || reg_addr == IDX_IRQ_LEVEL)
    |=> reg_rdata[7:4] == 4'h0)
    else $error("upper nibble not zero");
  chk_low_rsvd: assert property (
    reg_rd && reg_addr == IDX_BASE_LOW |=> reg_rdata[2:0] == 3'h0)
    else $error("base low bits not zero");
  chk_en_rsvd: assert property (
    reg_rd && reg_addr == IDX_ACTIVATE |=> reg_rdata[7:1] == 7'h00)
    else $error("activate reserved bits");
  chk_dma_rsvd: assert property (
    reg_rd && reg_addr == IDX_DMA_CHANNEL |=> reg_rdata[7:3] == 5'h00)
    else $error("dma reserved bits");
endmodule
bind logical_device_config_regs ldev_cfg_properties u_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .floppy_cfg(floppy_cfg),
  .uart_one_cfg(uart_one_cfg), .uart_two_cfg(uart_two_cfg),
  .pin_func(pin_func));

// ### tb_top.sv
// self-checking bench for the logical device configuration bank
// assumes the host model drives the port and the checker is bound
`timescale 1ns/1ps
module tb_top;
  import ldev_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic rd_seen = 1'b0;
  floppy_cfg_t floppy_cfg;
  uart_cfg_t uart_one_cfg;
  uart_base_t uart_two_cfg;
  pin_func_t pin_func;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h9;
  logic [7:0] v[20];
  logic [7:0] m;
  int n_mismatch = 0;
  int n_checks = 0;
  // device, index, reset value, writable mask
  logic [31:0] tbl[20] = '{32'h042B00CF, 32'h0028FFFF, 32'h00300001,
    32'h0060030F, 32'h0061F0F8, 32'h0070060F, 32'h00740207, 32'h00F0000F,
    32'h00F1000F, 32'h01300001, 32'h0160030F, 32'h0161F8F8, 32'h0170040F,
    32'h01F0000F, 32'h02300001, 32'h0260020F, 32'h0261F8F8, 32'h002E0000,
    32'h002F0000, 32'h00750000};
  always #10 ref_clk = ~ref_clk;
  logical_device_config_regs dut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .floppy_cfg(floppy_cfg),
    .uart_one_cfg(uart_one_cfg), .uart_two_cfg(uart_two_cfg),
    .pin_func(pin_func));
  host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rd_exp(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic chk_outs();
    check("floppy_cfg", floppy_cfg, {v[2][0], 4'h0, v[3][3:0],
      v[4][7:3], 3'h0, v[5][3:0], v[6][2:0], v[7][3:0], v[8][3:0]});
    check("uart_one_cfg", uart_one_cfg, {v[9][0], 4'h0,
      v[10][3:0], v[11][7:3], 3'h0, v[12][3:0], v[13][3],
      v[13][2:1] == 2'h0, v[13][0]});
    check("uart_two_cfg", uart_two_cfg, {v[14][0], 4'h0,
      v[15][3:0], v[16][7:3], 3'h0});
    check("pin_func", pin_func, {~v[1] & ~v[0], v[1] & ~v[0], v[0]});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // read answers stand one cycle after the strobe
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        check("read queue", 32'h1, 32'h0);
      end else begin
        check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    check("timeout", 32'h1, 32'h0);
    close_out();
  end
  initial begin
    for (int k = 0; k < 20; k++) v[k] = tbl[k][15:8];
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk_outs();
    host.wr(IDX_DEVICE_NUMBER, DEV_FLOPPY);
    host.wr(IDX_ALT_OVERRIDE, 8'hFF);
    rd_exp(IDX_ALT_OVERRIDE, 8'h00);
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 20; k++) begin
        host.wr(IDX_DEVICE_NUMBER, tbl[k][31:24]);
        rd_exp(tbl[k][23:16], v[k]);
        if (tbl[k][7:0] != 8'h00) begin
          m = rnd();
          host.wr(tbl[k][23:16], m);
          v[k] = m & tbl[k][7:0];
          rd_exp(tbl[k][23:16], v[k]);
        end
      end
      host.idle();
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk_outs();
    end
    host.wr(IDX_DEVICE_NUMBER, DEV_UART_ONE);
    rd_exp(IDX_ALT_OVERRIDE, v[0]);
    host.idle();
    // second reset in mid-run brings every register back
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 20; k++) v[k] = tbl[k][15:8];
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk_outs();
    rd_exp(IDX_BASE_LOW, v[4]);
    host.idle();
    repeat (3) @(posedge ref_clk);
    check("read queue left", exp_q.size(), 32'h0);
    close_out();
  end
endmodule
